// ---- design/vcem_monitor.sv ----
// Vacuum ejector condition, energy and wear trend monitor with an APB register file.
//
// The placing of the registers and register access over APB were decided locally.
`include "vcem_defines.svh"
//
// Overview of operation
// - In control mode, measure vacuum loss in mbar/s and compare with leakage limit.
// - Leakage under limit: decay to upper limit minus hysteresis, then suck again.
// - Leakage over limit: resume suction at once.
// - Second excess: continuous suction, leakage warning, status light yellow.
// - Try a dynamic pressure measurement each cycle start, compare with limits.
// - Dynamic pressure between lower limit minus hysteresis and upper limit warns.
// - Average leakage of the last cycle is sorted into bands and readable.
// - Autoset stores last leakage and evacuation time plus margin as limits.
// - Air share is active suction plus blow-off time over full cycle time.
// - Absolute air is computed only with an externally supplied pressure.
// - Absolute air clears at cycle start and updates through blow-off.
// - Energy per cycle counts own consumption plus valve coil energy.
// - Air share and energy are published only when the next cycle starts.
// - Leakage is measured only after suction stopped at the upper limit.
// - Leakage and quality clear at cycle start, then update as moving averages.
// - Dynamic pressure needs one second of uninterrupted suction to be valid.
// - Results under 5 mbar or over the upper limit are dropped; last kept.
// - Dynamic pressure and performance read unknown until the first valid result.
// - Quality rating falls as leakage rises and rises as leakage falls.
// - Performance is zero above lower limit minus hysteresis or with no result.
// - Evacuation time is ms from lower limit to upper limit in a cycle.
module vcem_monitor #(
  parameter int TICK_CYCLES = `VCEM_TICK_CYCLES,
  parameter int DYN_MEAS_MS = `VCEM_DYN_MEAS_MS,
  parameter int LEAK_WIN_MS = `VCEM_LEAK_WIN_MS,
  parameter logic [7:0] OWN_POWER = 8'h02,
  parameter logic [7:0] COIL_POWER = 8'h05
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // APB slave.
  input wire vcem_pkg::vcem_apb_req_t apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Process inputs.
  input wire vcem_pkg::vcem_sense_t sense,
  // Valve and status outputs.
  output logic suctionValveOn,
  output logic blowOffValveOn,
  output logic statusYellow,
  output logic leakWarn,
  output logic dynWarn
);
  import vcem_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Percentage of num over den, clamped to one hundred; zero for a zero base.
  function automatic logic [7:0] pctOf(input logic [31:0] num, input logic [31:0] den);
    logic [39:0] q;
    q = 40'h0;
    if (den == 32'h0) begin
      return 8'h00;
    end
    q = ({8'h00, num} * 40'h64) / {8'h00, den};
    if (q > 40'h64) begin
      return `VCEM_PCT_FULL;
    end
    return q[7:0];
  endfunction : pctOf

  // Adds a quarter as tolerance margin, saturating at the field width.
  function automatic logic [15:0] withMargin(input logic [15:0] v);
    logic [16:0] s;
    s = {1'b0, v} + {3'b000, v[15:2]} + 17'h00001;
    return s[16] ? 16'hFFFF : s[15:0];
  endfunction : withMargin

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  vcem_state_t state_reg, state_next;
  logic ctrlMode_reg, autoset_reg, extValid_reg, autosetPrev_reg;
  logic [15:0] upper_reg, upperHys_reg, lower_reg, lowerHys_reg;
  logic [15:0] leakLimit_reg, evacLimit_reg, extPress_reg, blowMs_reg;
  logic [7:0] nozzle_reg;
  logic [15:0] tickCnt_reg;
  logic tick;
  logic reqPrev_reg;
  logic cycleStart;
  logic [15:0] winCnt_reg, winStart_reg;
  logic [31:0] leakRate;
  logic leakCheck, leakExceed;
  logic [1:0] exceedCnt_reg;
  logic [15:0] leakAvg_reg, lastLeak_reg;
  logic leakHasSample_reg;
  logic [7:0] quality_reg;
  logic [15:0] evacCnt_reg, evacTime_reg;
  logic h1Seen_reg;
  logic [15:0] dynCnt_reg, dyn_reg;
  logic dynArmed_reg, dynKnown_reg;
  logic [7:0] perf_reg;
  logic [15:0] blowCnt_reg;
  logic [31:0] activeMs_reg, totalMs_reg, energyAcc_reg, energy_reg, airAbs_reg;
  logic [7:0] airPct_reg;
  logic [1:0] leakBand;
  logic [15:0] holdFloor, dynLowThr;
  logic leakWarn_reg, dynWarn_reg;
  logic [15:0] vac;
  logic valveAir;
  logic setupPhase, accessWrite, mapped;
  logic [31:0] readMux;
  logic [31:0] prdata_reg;

  assign vac = sense.vacuumMbar;
  assign holdFloor = (upper_reg > upperHys_reg) ? (upper_reg - upperHys_reg) : 16'h0000;
  assign dynLowThr = (lower_reg > lowerHys_reg) ? (lower_reg - lowerHys_reg) : 16'h0000;
  assign cycleStart = sense.suctionReq & ~reqPrev_reg;
  assign valveAir = (state_reg == ST_EVAC) || (state_reg == ST_CONT) || (state_reg == ST_BLOW);

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick and request edge.

  // All measurements run on a 1 ms tick so the counters stay narrow.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tickCnt_reg <= 16'h0000;
      reqPrev_reg <= 1'b0;
    end else begin
      reqPrev_reg <= sense.suctionReq;
      tickCnt_reg <= tick ? 16'h0000 : tickCnt_reg + 16'h0001;
    end
  end

  assign tick = (tickCnt_reg == 16'(TICK_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // Suction control sequence.

  // The window restarts every LEAK_WIN_MS; the drop is scaled by 1000 over the default window, so to one second only at the default.
  assign leakRate = (winStart_reg > vac) ? (32'(winStart_reg - vac) * 32'(`VCEM_LEAK_SCALE)) : 32'h0;
  assign leakCheck = (state_reg == ST_HOLD) && tick && (winCnt_reg == 16'(LEAK_WIN_MS - 1));
  assign leakExceed = leakCheck && (leakRate > {16'h0000, leakLimit_reg});

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (cycleStart) begin
          state_next = ST_EVAC;
        end
      end
      ST_EVAC: begin
        if (!sense.suctionReq) begin
          state_next = ST_BLOW;
        end else if (ctrlMode_reg && vac >= upper_reg) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!sense.suctionReq) begin
          state_next = ST_BLOW;
        end else if (vac < holdFloor) begin
          state_next = ST_EVAC;
        end else if (leakExceed) begin
          state_next = (exceedCnt_reg != 2'h0) ? ST_CONT : ST_EVAC;
        end
      end
      ST_CONT: begin
        if (!sense.suctionReq) begin
          state_next = ST_BLOW;
        end
      end
      ST_BLOW: begin
        if (cycleStart) begin
          state_next = ST_EVAC;
        end else if (tick && blowCnt_reg >= blowMs_reg) begin
          state_next = ST_IDLE;
        end
      end
    endcase
  end

  // Phase register and blow-off timer.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      blowCnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      if (state_reg != ST_BLOW) begin
        blowCnt_reg <= 16'h0000;
      end else if (tick) begin
        blowCnt_reg <= blowCnt_reg + 16'h0001;
      end
    end
  end

  assign suctionValveOn = (state_reg == ST_EVAC) || (state_reg == ST_CONT);
  assign blowOffValveOn = (state_reg == ST_BLOW);

  ////////////////////////////////////////////////////////////////////////////
  // Leakage monitoring and quality rating.

  // A new window opens on every entry to the hold phase and after every check.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      winCnt_reg <= 16'h0000;
      winStart_reg <= 16'h0000;
    end else if (state_reg != ST_HOLD || leakCheck) begin
      winCnt_reg <= 16'h0000;
      winStart_reg <= vac;
    end else if (tick) begin
      winCnt_reg <= winCnt_reg + 16'h0001;
    end
  end

  // Excess count and warning live for one cycle; a new cycle starts them over.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      exceedCnt_reg <= 2'h0;
      leakWarn_reg <= 1'b0;
    end else if (cycleStart) begin
      exceedCnt_reg <= 2'h0;
      leakWarn_reg <= 1'b0;
    end else if (leakExceed && state_reg == ST_HOLD) begin
      if (exceedCnt_reg != 2'h3) begin
        exceedCnt_reg <= exceedCnt_reg + 2'h1;
      end
      if (exceedCnt_reg != 2'h0) begin
        leakWarn_reg <= 1'b1;
      end
    end
  end

  // Moving average of the rate: first sample loads, later ones average in by half.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      leakAvg_reg <= 16'h0000;
      leakHasSample_reg <= 1'b0;
      lastLeak_reg <= 16'h0000;
      quality_reg <= `VCEM_PCT_FULL;
    end else if (cycleStart) begin
      lastLeak_reg <= leakAvg_reg;
      leakAvg_reg <= 16'h0000;
      leakHasSample_reg <= 1'b0;
      quality_reg <= `VCEM_PCT_FULL;
    end else if (leakCheck) begin
      leakHasSample_reg <= 1'b1;
      if (!leakHasSample_reg) begin
        leakAvg_reg <= (leakRate > 32'hFFFF) ? 16'hFFFF : leakRate[15:0];
        quality_reg <= `VCEM_PCT_FULL - pctOf(leakRate, {15'h0, leakLimit_reg, 1'b0});
      end else begin
        leakAvg_reg <= 16'(({16'h0, leakAvg_reg} + ((leakRate > 32'hFFFF) ? 32'hFFFF : leakRate)) >> 1);
        quality_reg <= `VCEM_PCT_FULL - pctOf(32'(({16'h0, leakAvg_reg} + leakRate) >> 1),
                                              {15'h0, leakLimit_reg, 1'b0});
      end
    end
  end

  // Bands of last-cycle leakage relative to the permitted limit.
  always_comb begin
    if ({1'b0, lastLeak_reg} < {2'b00, leakLimit_reg[15:1]}) begin
      leakBand = 2'h0;
    end else if ({1'b0, lastLeak_reg} < {1'b0, leakLimit_reg}) begin
      leakBand = 2'h1;
    end else if ({1'b0, lastLeak_reg} < {leakLimit_reg, 1'b0}) begin
      leakBand = 2'h2;
    end else begin
      leakBand = 2'h3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Evacuation time.

  // Counts only the first rise of each cycle, from the lower to the upper limit.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      evacCnt_reg <= 16'h0000;
      evacTime_reg <= 16'h0000;
      h1Seen_reg <= 1'b0;
    end else if (cycleStart) begin
      evacCnt_reg <= 16'h0000;
      h1Seen_reg <= 1'b0;
    end else if (!h1Seen_reg && suctionValveOn) begin
      if (vac >= upper_reg) begin
        evacTime_reg <= evacCnt_reg;
        h1Seen_reg <= 1'b1;
      end else if (tick && vac >= lower_reg && evacCnt_reg != 16'hFFFF) begin
        evacCnt_reg <= evacCnt_reg + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Dynamic pressure and performance rating.

  // Any break in suction before the window ends drops the attempt for this cycle.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dynCnt_reg <= 16'h0000;
      dynArmed_reg <= 1'b0;
      dyn_reg <= 16'h0000;
      dynKnown_reg <= 1'b0;
      perf_reg <= 8'h00;
      dynWarn_reg <= 1'b0;
    end else if (cycleStart) begin
      dynCnt_reg <= 16'h0000;
      dynArmed_reg <= 1'b1;
    end else if (dynArmed_reg) begin
      if (!suctionValveOn) begin
        dynArmed_reg <= 1'b0;
      end else if (tick && dynCnt_reg == 16'(DYN_MEAS_MS - 1)) begin
        dynArmed_reg <= 1'b0;
        if (vac >= `VCEM_DYN_MIN_MBAR && vac <= upper_reg) begin
          dyn_reg <= vac;
          dynKnown_reg <= 1'b1;
          dynWarn_reg <= (vac > dynLowThr) && (vac < upper_reg);
          perf_reg <= (vac == 16'h0000 || vac > dynLowThr) ? 8'h00 :
                      (`VCEM_PCT_FULL - pctOf({16'h0, vac}, {16'h0, dynLowThr}));
        end
      end else if (tick) begin
        dynCnt_reg <= dynCnt_reg + 16'h0001;
      end
    end
  end

  assign leakWarn = leakWarn_reg;
  assign dynWarn = dynWarn_reg;
  assign statusYellow = leakWarn_reg | dynWarn_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Energy monitoring.

  // Running sums of the open cycle; air share and energy publish at the next start.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      activeMs_reg <= 32'h0;
      totalMs_reg <= 32'h0;
      energyAcc_reg <= 32'h0;
      energy_reg <= 32'h0;
      airPct_reg <= 8'h00;
    end else if (cycleStart) begin
      airPct_reg <= pctOf(activeMs_reg, totalMs_reg);
      energy_reg <= energyAcc_reg;
      activeMs_reg <= 32'h0;
      totalMs_reg <= 32'h0;
      energyAcc_reg <= 32'h0;
    end else if (tick) begin
      totalMs_reg <= totalMs_reg + 32'h1;
      if (valveAir) begin
        activeMs_reg <= activeMs_reg + 32'h1;
      end
      energyAcc_reg <= energyAcc_reg + {24'h0, OWN_POWER} + (valveAir ? {24'h0, COIL_POWER} : 32'h0);
    end
  end

  // Absolute air follows the blow-off too, so it may still move after the valve closes.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      airAbs_reg <= 32'h0;
    end else if (cycleStart) begin
      airAbs_reg <= 32'h0;
    end else if (tick && valveAir && extValid_reg) begin
      airAbs_reg <= airAbs_reg + ((32'(extPress_reg) * {24'h0, nozzle_reg}) >> 8);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register file.

  assign setupPhase = apbReq.psel & ~apbReq.penable;
  assign accessWrite = apbReq.psel & apbReq.penable & apbReq.pwrite;

  // Read decode; unmapped words read zero and answer with an error.
  always_comb begin
    mapped = 1'b1;
    readMux = 32'h0;
    unique case (apbReq.paddr)
      `VCEM_OFS_CTRL: readMux = {29'h0, extValid_reg, autoset_reg, ctrlMode_reg};
      `VCEM_OFS_UPPER: readMux = {upperHys_reg, upper_reg};
      `VCEM_OFS_LOWER: readMux = {lowerHys_reg, lower_reg};
      `VCEM_OFS_LIMITS: readMux = {evacLimit_reg, leakLimit_reg};
      `VCEM_OFS_SUPPLY: readMux = {8'h0, nozzle_reg, extPress_reg};
      `VCEM_OFS_BLOW: readMux = {16'h0, blowMs_reg};
      `VCEM_OFS_STATUS: readMux = {21'h0, state_reg, leakBand, dynKnown_reg, statusYellow, dynWarn_reg, leakWarn_reg};
      `VCEM_OFS_LEAK: readMux = {8'h0, quality_reg, leakAvg_reg};
      `VCEM_OFS_DYN: readMux = {evacTime_reg, perf_reg, dyn_reg[7:0]} | {16'h0, dyn_reg[15:8], 8'h0};
      `VCEM_OFS_AIRPCT: readMux = {24'h0, airPct_reg};
      `VCEM_OFS_AIRABS: readMux = airAbs_reg;
      `VCEM_OFS_ENERGY: readMux = energy_reg;
      default: mapped = 1'b0;
    endcase
  end

  // Read data is latched in the setup cycle so prdata comes from a flip-flop.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata_reg <= 32'h0;
    end else if (setupPhase) begin
      prdata_reg <= readMux;
    end
  end

  assign prdata = prdata_reg;
  assign pready = apbReq.psel & apbReq.penable;
  assign pslverr = apbReq.psel & apbReq.penable & ~mapped;

  // Configuration writes; autoset overrides the two limits on the same edge.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ctrlMode_reg <= 1'b1;
      autoset_reg <= 1'b0;
      autosetPrev_reg <= 1'b0;
      extValid_reg <= 1'b0;
      upper_reg <= `VCEM_RST_UPPER;
      upperHys_reg <= `VCEM_RST_UPPER_HYS;
      lower_reg <= `VCEM_RST_LOWER;
      lowerHys_reg <= `VCEM_RST_LOWER_HYS;
      leakLimit_reg <= `VCEM_RST_LEAK_LIMIT;
      evacLimit_reg <= `VCEM_RST_EVAC_LIMIT;
      extPress_reg <= 16'h0000;
      nozzle_reg <= `VCEM_RST_NOZZLE;
      blowMs_reg <= `VCEM_RST_BLOW_MS;
    end else begin
      autosetPrev_reg <= autoset_reg;
      if (accessWrite) begin
        unique case (apbReq.paddr)
          `VCEM_OFS_CTRL: begin
            ctrlMode_reg <= apbReq.pwdata[`VCEM_CTRL_MODE_BIT];
            autoset_reg <= apbReq.pwdata[`VCEM_CTRL_AUTOSET_BIT];
            extValid_reg <= apbReq.pwdata[`VCEM_CTRL_EXTVALID_BIT];
          end
          `VCEM_OFS_UPPER: begin
            upper_reg <= apbReq.pwdata[15:0];
            upperHys_reg <= apbReq.pwdata[31:16];
          end
          `VCEM_OFS_LOWER: begin
            lower_reg <= apbReq.pwdata[15:0];
            lowerHys_reg <= apbReq.pwdata[31:16];
          end
          `VCEM_OFS_LIMITS: begin
            leakLimit_reg <= apbReq.pwdata[15:0];
            evacLimit_reg <= apbReq.pwdata[31:16];
          end
          `VCEM_OFS_SUPPLY: begin
            extPress_reg <= apbReq.pwdata[15:0];
            nozzle_reg <= apbReq.pwdata[23:16];
          end
          `VCEM_OFS_BLOW: blowMs_reg <= apbReq.pwdata[15:0];
          default: begin
          end
        endcase
      end
      if (autoset_reg && !autosetPrev_reg) begin
        leakLimit_reg <= withMargin(lastLeak_reg);
        evacLimit_reg <= withMargin(evacTime_reg);
      end
    end
  end

endmodule : vcem_monitor

// ---- pkg/vcem_defines.svh ----
// Constants of the vacuum condition and energy monitor: timing, offsets, fields and reset values.
`ifndef VCEM_DEFINES_SVH
`define VCEM_DEFINES_SVH

// Timing: system clock in kHz, the base tick in ms and the cycles per tick.
`define VCEM_CLK_KHZ 25000
`define VCEM_TICK_MS 1
`define VCEM_TICK_CYCLES (`VCEM_CLK_KHZ * `VCEM_TICK_MS)
`define VCEM_DYN_MEAS_MS 1000
`define VCEM_LEAK_WIN_MS 100
`define VCEM_LEAK_SCALE (1000 / `VCEM_LEAK_WIN_MS)
`define VCEM_DYN_MIN_MBAR 16'h0005
`define VCEM_PCT_FULL 8'h64

// Register byte offsets.
`define VCEM_OFS_CTRL 12'h000
`define VCEM_OFS_UPPER 12'h004
`define VCEM_OFS_LOWER 12'h008
`define VCEM_OFS_LIMITS 12'h00C
`define VCEM_OFS_SUPPLY 12'h010
`define VCEM_OFS_BLOW 12'h014
`define VCEM_OFS_STATUS 12'h020
`define VCEM_OFS_LEAK 12'h024
`define VCEM_OFS_DYN 12'h028
`define VCEM_OFS_AIRPCT 12'h02C
`define VCEM_OFS_AIRABS 12'h030
`define VCEM_OFS_ENERGY 12'h034

// Field positions in the control register.
`define VCEM_CTRL_MODE_BIT 0
`define VCEM_CTRL_AUTOSET_BIT 1
`define VCEM_CTRL_EXTVALID_BIT 2

// Reset values of the configuration.
`define VCEM_RST_UPPER 16'h02EE
`define VCEM_RST_UPPER_HYS 16'h0032
`define VCEM_RST_LOWER 16'h0226
`define VCEM_RST_LOWER_HYS 16'h000A
`define VCEM_RST_LEAK_LIMIT 16'h00FA
`define VCEM_RST_EVAC_LIMIT 16'h07D0
`define VCEM_RST_NOZZLE 8'h10
`define VCEM_RST_BLOW_MS 16'h00C8

`endif

// ---- pkg/vcem_pkg.sv ----
// Types of the vacuum condition and energy monitor.
package vcem_pkg;

  // Suction cycle phases, one-hot.
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_EVAC = 5'b00010,
    ST_HOLD = 5'b00100,
    ST_CONT = 5'b01000,
    ST_BLOW = 5'b10000
  } vcem_state_t;

  // APB request from the bus master.
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } vcem_apb_req_t;

  // Process inputs of the ejector.
  typedef struct packed {
    logic suctionReq;
    logic [15:0] vacuumMbar;
  } vcem_sense_t;

endpackage : vcem_pkg

// ---- verification/vcem_checker.sv ----
// Port-level assertions of the monitor.
module vcem_checker (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Process inputs.
  input wire vcem_pkg::vcem_sense_t sense,
  // Valves and warnings.
  input wire logic suctionValveOn,
  input wire logic blowOffValveOn,
  input wire logic statusYellow,
  input wire logic leakWarn,
  input wire logic dynWarn
);
  timeunit 1ns;
  timeprecision 1ns;
  import vcem_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  // The light has no state of its own, so a stale warning shows at once.
  chk_yellow_follows: assert property (statusYellow == (leakWarn || dynWarn))
    else $error("status light disagrees with warnings");
  chk_valves_apart: assert property (!(suctionValveOn && blowOffValveOn))
    else $error("both valves on");
  chk_start_sucks: assert property ($rose(sense.suctionReq) ##1 sense.suctionReq |-> ##[0:2] suctionValveOn)
    else $error("no suction after cycle start");
  chk_release_blows: assert property ($fell(sense.suctionReq) ##1 !sense.suctionReq |-> ##[0:2] blowOffValveOn)
    else $error("no blow-off after release");
  chk_warn_cleared: assert property ($rose(sense.suctionReq) |-> ##[1:3] !leakWarn)
    else $error("leak warning kept into new cycle");
  chk_warn_sucks: assert property ($rose(leakWarn) |-> ##[0:1] suctionValveOn)
    else $error("leak warning without continuous suction");
  chk_warn_held: assert property ($fell(leakWarn) |-> sense.suctionReq)
    else $error("leak warning dropped outside cycle start");
  chk_dyn_in_suction: assert property ($changed(dynWarn) |-> $past(suctionValveOn, 2))
    else $error("dynamic warning changed without suction");
endmodule : vcem_checker

bind vcem_monitor vcem_checker vcem_checker_i (.sys_clk(sys_clk), .reset(reset), .sense(sense),
  .suctionValveOn(suctionValveOn), .blowOffValveOn(blowOffValveOn), .statusYellow(statusYellow),
  .leakWarn(leakWarn), .dynWarn(dynWarn));

// ---- verification/vcem_monitor_tb.sv ----
// Self-checking bench of the vacuum monitor.
`include "vcem_defines.svh"
module vcem_monitor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import vcem_pkg::*;
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;
  logic sys_clk, reset, req, pready, pslverr;
  logic suctionValveOn, blowOffValveOn, statusYellow, leakWarn, dynWarn;
  logic [15:0] ceiling, vac, seed;
  logic [3:0] leakPeriod;
  logic [31:0] prdata;
  logic [65:0] note;
  logic [65:0] expQ[$];
  vcem_apb_req_t apbReq;
  vcem_sense_t sense;
  int fail_count = 0;
  int checks_done = 0;
  assign sense = '{suctionReq: req, vacuumMbar: vac};
  always #20 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  // Short tick and windows keep each suction cycle but the slow-leak one (1500 clocks) to a few hundred clocks.
  vcem_monitor #(.TICK_CYCLES(10), .DYN_MEAS_MS(20), .LEAK_WIN_MS(10)) vcem_monitor_i (.sys_clk(sys_clk),
    .reset(reset), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense(sense),
    .suctionValveOn(suctionValveOn), .blowOffValveOn(blowOffValveOn), .statusYellow(statusYellow),
    .leakWarn(leakWarn), .dynWarn(dynWarn));
  vcem_plant_model vcem_plant_model_i (.sys_clk(sys_clk), .reset(reset), .suctionValveOn(suctionValveOn),
    .blowOffValveOn(blowOffValveOn), .ceiling(ceiling), .leakPeriod(leakPeriod), .vacuumMbar(vac));
  ////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic give_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Bounded wait; a hang ends the run as a failure.
  task automatic waitFor(ref logic sig, input logic val, input int lim);
    int n;
    n = 0;
    while (sig !== val && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (sig !== val) begin
      fail_count++;
      give_verdict();
    end
  endtask : waitFor
  // One APB transfer; a read leaves its masked expectation in the queue.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] m,
                     input logic [32:0] e);
    @(posedge sys_clk);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    if (!wr) expQ.push_back({m, e});
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    waitFor(pready, 1'b1, 20);
    apbReq <= '0;
  endtask : apb
  task automatic endCycle();
    req <= 1'b0;
    waitFor(blowOffValveOn, 1'b1, 10);
    waitFor(blowOffValveOn, 1'b0, 400);
  endtask : endCycle
  // Reads are judged where they complete, against the oldest note.
  always @(posedge sys_clk) begin
    if (apbReq.psel && apbReq.penable && pready && !apbReq.pwrite) begin
      note = expQ.pop_front();
      check({pslverr, prdata} & note[65:33], note[32:0]);
    end
  end
  ////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    req = 1'b0;
    ceiling = 16'h00C8;
    leakPeriod = 4'h8;
    apbReq = '0;
    seed = 16'h0032;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    apb(1'b0, `VCEM_OFS_CTRL, '0, ALL, 33'h000000001);
    apb(1'b0, `VCEM_OFS_UPPER, '0, ALL, {1'b0, `VCEM_RST_UPPER_HYS, `VCEM_RST_UPPER});
    apb(1'b0, `VCEM_OFS_LIMITS, '0, ALL, {1'b0, `VCEM_RST_EVAC_LIMIT, `VCEM_RST_LEAK_LIMIT});
    apb(1'b0, `VCEM_OFS_STATUS, '0, ALL, 33'h000000040);
    apb(1'b0, 12'hFFC, '0, ALL, 33'h100000000);
    // Autoset before any cycle leaves only the margin's one in each limit; the limits are then restored.
    apb(1'b1, `VCEM_OFS_CTRL, 32'h00000003, '0, '0);
    apb(1'b0, `VCEM_OFS_LIMITS, '0, ALL, 33'h000010001);
    apb(1'b1, `VCEM_OFS_LIMITS, {`VCEM_RST_EVAC_LIMIT, `VCEM_RST_LEAK_LIMIT}, '0, '0);
    apb(1'b1, `VCEM_OFS_BLOW, 32'h0000000A, '0, '0);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      apb(1'b1, `VCEM_OFS_SUPPLY, {8'h00, `VCEM_RST_NOZZLE, seed}, '0, '0);
      apb(1'b0, `VCEM_OFS_SUPPLY, '0, ALL, {9'h000, `VCEM_RST_NOZZLE, seed});
    end
    apb(1'b1, `VCEM_OFS_CTRL, 32'h00000005, '0, '0);
    // Free flow at 200 mbar: valid result, no warning.
    req <= 1'b1;
    repeat (300) @(posedge sys_clk);
    check({32'h0, dynWarn}, 33'h0);
    apb(1'b0, `VCEM_OFS_DYN, '0, 33'h0000000FF, 33'h0000000C8);
    // A 3 mbar result is too low and must leave the old one standing.
    endCycle();
    ceiling <= 16'h0003;
    req <= 1'b1;
    repeat (300) @(posedge sys_clk);
    apb(1'b0, `VCEM_OFS_DYN, '0, 33'h0000000FF, 33'h0000000C8);
    // The last cycle had a valve open for all but at most one tick: about 40 ticks of 7 units.
    apb(1'b0, `VCEM_OFS_AIRPCT, '0, 33'h0000000F8, 33'h000000060);
    apb(1'b0, `VCEM_OFS_ENERGY, '0, 33'h0FFFFFF00, 33'h000000100);
    // Supply 400 with nozzle 16 adds 25 per suction tick, about 31 ticks into this cycle.
    apb(1'b0, `VCEM_OFS_AIRABS, '0, 33'h0FFFFFE00, 33'h000000200);
    // 600 mbar lies in the warning band between the limits.
    endCycle();
    ceiling <= 16'h0258;
    req <= 1'b1;
    repeat (300) @(posedge sys_clk);
    check({32'h0, statusYellow}, 33'h1);
    apb(1'b0, `VCEM_OFS_STATUS, '0, 33'h000000008, 33'h000000008);
    // Fast leak twice over the limit forces continuous suction.
    endCycle();
    ceiling <= 16'h03E8;
    leakPeriod <= 4'h3;
    req <= 1'b1;
    waitFor(leakWarn, 1'b1, 6000);
    check({32'h0, suctionValveOn}, 33'h1);
    // Slow leak decays to the lower switching point without a warning.
    endCycle();
    leakPeriod <= 4'h8;
    req <= 1'b1;
    repeat (1500) @(posedge sys_clk);
    check({32'h0, leakWarn}, 33'h0);
    endCycle();
    give_verdict();
  end
endmodule : vcem_monitor_tb

// ---- verification/vcem_plant_model.sv ----
// Vacuum circuit model that the ejector pumps down and that leaks when left alone.
module vcem_plant_model (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Valves from the monitor.
  input wire logic suctionValveOn,
  input wire logic blowOffValveOn,
  // Plateau of free suction and cycles per mbar lost.
  input wire logic [15:0] ceiling,
  input wire logic [3:0] leakPeriod,
  // Sensor reading.
  output logic [15:0] vacuumMbar
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] vac_reg;
  logic [3:0] leakCnt_reg;
  ////////////////////////////////////////
  // Fast pump-down keeps the plateau flat for most of a measurement window.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vac_reg <= 16'h0000;
      leakCnt_reg <= 4'h0;
    end else if (blowOffValveOn) begin
      vac_reg <= 16'h0000;
    end else if (suctionValveOn) begin
      vac_reg <= (vac_reg + 16'h0032 >= ceiling) ? ceiling : vac_reg + 16'h0032;
    end else if (leakCnt_reg + 4'h1 >= leakPeriod) begin
      leakCnt_reg <= 4'h0;
      vac_reg <= (vac_reg == 16'h0000) ? vac_reg : vac_reg - 16'h0001;
    end else begin
      leakCnt_reg <= leakCnt_reg + 4'h1;
    end
  end
  assign vacuumMbar = vac_reg; // Vented circuit reads zero, never a stale value.
endmodule : vcem_plant_model
